// ### fbsc_pkg.sv
// Purpose: Shared constants and types for the flag branch and stone conversion unit.
// Assumes: One processor clock; operands arrive already fetched by the instruction stream.
// Notes:   Cycle counts include the cycle in which the instruction is accepted.
package fbsc_pkg;

    typedef enum logic [2:0] {
        OP_OVF_REL = 3'h0,
        OP_OVF_ABS = 3'h1,
        OP_POS_REL = 3'h2,
        OP_POS_ABS = 3'h3,
        OP_STONE   = 3'h4
    } fbsc_op_t;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_WAIT  = 5'h02,
        ST_DIVLB = 5'h04,
        ST_DIVST = 5'h08,
        ST_HOLD  = 5'h10
    } fbsc_state_t;

    localparam logic [1:0] REL_BYTES   = 2'h2;
    localparam logic [1:0] ABS_BYTES   = 2'h3;
    localparam logic [1:0] STONE_BYTES = 2'h3;

    localparam logic [7:0] REL_CYCLES   = 8'h03;
    localparam logic [7:0] ABS_CYCLES   = 8'h04;
    localparam logic [7:0] STONE_CYCLES = 8'hb9;

    // Datapath width of the shared serial divider.
    localparam int         DIV_W        = 40;
    localparam logic [5:0] DIV_STEPS    = 6'h28;
    // Weight scaling: tenths of a pound = weight * 10000 / 4535924 (units of 100 mg).
    localparam logic [39:0] MASS_SCALE  = 40'h0000002710;
    localparam logic [39:0] LB_DIVISOR  = 40'h0000453674;
    // Tenths of a pound in one stone, and the weight of the stone digit positions.
    localparam logic [39:0] ST_DIVISOR  = 40'h000000008c;
    localparam logic [39:0] ST_WEIGHT   = 40'h00000003e8;

endpackage

// ### fbsc_unit.sv
// Purpose: Executes overflow branch, non-negative branch and mass to stone conversion.
// Assumes: Flags and accumulator x are stable in the cycle the instruction is started.
// Notes:   Stone result is stones * 1000 + tenths of pounds, a plain binary number.
`timescale 1ns/1ps

// Behaviour
// - Overflow branch loads target address only when preceding overflow flag is set.
// - Non-negative branch loads target address only when sign flag is clear.
// - Branches are 2 bytes relative, 3 bytes absolute; fetch length follows.
// - Branches take 3 cycles relative and 4 cycles absolute.
// - Target comes from label operand as relative offset or absolute address.
// - Stone conversion replaces x, weight in 100mg units, 3 bytes, 185 cycles.
// - Result has up to three stone digit positions above the pounds positions for 24-bit x.
// - Result is a plain number the display formatting instruction takes directly.
module fbsc_unit #(
    parameter int PCW = 16,
    parameter int XW  = 24
) (
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    input  wire logic                  start,
    input  fbsc_pkg::fbsc_op_t         opcode,
    input  wire logic [PCW-1:0]        pcIn,
    input  wire logic [7:0]            relOffset,
    input  wire logic [PCW-1:0]        absAddr,
    input  wire logic                  overflowFlag,
    input  wire logic                  signFlag,
    input  wire logic [XW-1:0]         xIn,
    output logic                       busy_q,
    output logic                       done_q,
    output logic [1:0]                 fetchLen_q,
    output logic                       branchTaken_q,
    output logic [PCW-1:0]             pc_q,
    output logic                       xLoad_q,
    output logic [XW-1:0]              xOut_q
);

    // The 40-bit divider holds x * 10000 only while x stays within 26 bits.
    if (PCW < 8 || PCW > 32 || XW < 16 || XW > 26) begin : gBadParams
        $error("fbsc_unit: unsupported PCW or XW");
    end

    fbsc_pkg::fbsc_state_t state_q;
    logic [7:0]            cnt_q;
    logic [7:0]            total_q;
    logic [PCW-1:0]        target_q;
    logic [PCW-1:0]        seqPc_q;
    logic                  cond_q;
    logic                  isStone_q;
    logic [fbsc_pkg::DIV_W-1:0] rem_q;
    logic [fbsc_pkg::DIV_W-1:0] quo_q;
    logic [fbsc_pkg::DIV_W-1:0] dvs_q;
    logic [5:0]            step_q;
    logic [fbsc_pkg::DIV_W-1:0] stones_q;

    logic                  accept;
    logic                  isAbs;
    logic [1:0]            lenNow;
    logic [PCW-1:0]        seqPc;
    logic [PCW-1:0]        relTarget;
    logic                  condNow;
    logic                  finish;
    logic [fbsc_pkg::DIV_W-1:0] remShift;
    logic                  remGe;
    logic [fbsc_pkg::DIV_W-1:0] stoneResult;

    assign accept  = start && !busy_q;
    assign isAbs   = (opcode == fbsc_pkg::OP_OVF_ABS) || (opcode == fbsc_pkg::OP_POS_ABS);
    // Fetch length of the accepted instruction.
    assign lenNow  = (opcode == fbsc_pkg::OP_STONE) ? fbsc_pkg::STONE_BYTES :
                     isAbs ? fbsc_pkg::ABS_BYTES : fbsc_pkg::REL_BYTES;
    assign seqPc   = pcIn + PCW'(lenNow);
    // Relative offsets count from the instruction that follows the branch.
    assign relTarget = seqPc + PCW'(signed'(relOffset));
    always_comb begin
        condNow = 1'b0;
        case (opcode)
            fbsc_pkg::OP_OVF_REL, fbsc_pkg::OP_OVF_ABS: condNow = overflowFlag;
            fbsc_pkg::OP_POS_REL, fbsc_pkg::OP_POS_ABS: condNow = !signFlag;
            default: condNow = 1'b0;
        endcase
    end
    assign finish  = busy_q && (cnt_q == total_q);

    // One restoring divider step: shift in the next dividend bit, subtract when it fits.
    assign remShift = {rem_q[fbsc_pkg::DIV_W-2:0], quo_q[fbsc_pkg::DIV_W-1]};
    assign remGe    = remShift >= dvs_q;
    assign stoneResult = stones_q * fbsc_pkg::ST_WEIGHT + rem_q;

    // Instruction capture on acceptance.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            total_q    <= 8'h00;
            target_q   <= '0;
            seqPc_q    <= '0;
            cond_q     <= 1'b0;
            isStone_q  <= 1'b0;
            fetchLen_q <= 2'h0;
        end else if (accept) begin
            total_q    <= (opcode == fbsc_pkg::OP_STONE) ? fbsc_pkg::STONE_CYCLES :
                          isAbs ? fbsc_pkg::ABS_CYCLES : fbsc_pkg::REL_CYCLES;
            target_q   <= isAbs ? absAddr : relTarget;
            seqPc_q    <= seqPc;
            cond_q     <= condNow;
            isStone_q  <= (opcode == fbsc_pkg::OP_STONE);
            fetchLen_q <= lenNow;
        end
    end

    // Cycle counter; the accept cycle counts as the first cycle.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
            cnt_q  <= 8'h00;
        end else if (accept) begin
            busy_q <= 1'b1;
            cnt_q  <= 8'h01;
        end else if (finish) begin
            busy_q <= 1'b0;
            cnt_q  <= 8'h00;
        end else if (busy_q) begin
            cnt_q  <= cnt_q + 8'h01;
        end
    end

    // Sequencer: two divisions, then hold until the fixed cycle count has elapsed.
    // The fixed count hides the data-dependent work so software timing stays exact.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_q  <= fbsc_pkg::ST_IDLE;
            rem_q    <= '0;
            quo_q    <= '0;
            dvs_q    <= '0;
            step_q   <= 6'h00;
            stones_q <= '0;
        end else begin
            case (state_q)
                fbsc_pkg::ST_IDLE: begin
                    if (accept && opcode == fbsc_pkg::OP_STONE) begin
                        rem_q   <= '0;
                        quo_q   <= fbsc_pkg::DIV_W'(xIn) * fbsc_pkg::MASS_SCALE;
                        dvs_q   <= fbsc_pkg::LB_DIVISOR;
                        step_q  <= 6'h00;
                        state_q <= fbsc_pkg::ST_DIVLB;
                    end else if (accept) begin
                        state_q <= fbsc_pkg::ST_WAIT;
                    end
                end
                fbsc_pkg::ST_WAIT: begin
                    if (finish) begin
                        state_q <= fbsc_pkg::ST_IDLE;
                    end
                end
                fbsc_pkg::ST_DIVLB, fbsc_pkg::ST_DIVST: begin
                    rem_q  <= remGe ? remShift - dvs_q : remShift;
                    quo_q  <= {quo_q[fbsc_pkg::DIV_W-2:0], remGe};
                    step_q <= step_q + 6'h01;
                    if (step_q == fbsc_pkg::DIV_STEPS - 6'h01) begin
                        if (state_q == fbsc_pkg::ST_DIVLB) begin
                            // Tenths of pounds become the next dividend.
                            rem_q   <= '0;
                            quo_q   <= {quo_q[fbsc_pkg::DIV_W-2:0], remGe};
                            dvs_q   <= fbsc_pkg::ST_DIVISOR;
                            step_q  <= 6'h00;
                            state_q <= fbsc_pkg::ST_DIVST;
                        end else begin
                            stones_q <= {quo_q[fbsc_pkg::DIV_W-2:0], remGe};
                            state_q  <= fbsc_pkg::ST_HOLD;
                        end
                    end
                end
                fbsc_pkg::ST_HOLD: begin
                    if (finish) begin
                        state_q <= fbsc_pkg::ST_IDLE;
                    end
                end
                default: state_q <= fbsc_pkg::ST_IDLE;
            endcase
        end
    end

    // Completion outputs.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            done_q        <= 1'b0;
            branchTaken_q <= 1'b0;
            pc_q          <= '0;
            xLoad_q       <= 1'b0;
            xOut_q        <= '0;
        end else begin
            done_q  <= finish;
            xLoad_q <= finish && isStone_q;
            if (finish) begin
                branchTaken_q <= cond_q && !isStone_q;
                pc_q          <= (cond_q && !isStone_q) ? target_q : seqPc_q;
                if (isStone_q) begin
                    xOut_q <= XW'(stoneResult);
                end
            end
        end
    end

    AST_OVF_TAKEN: assert property (@(posedge mclk) disable iff (!rst_n)
        accept && opcode == fbsc_pkg::OP_OVF_REL && overflowFlag
        |-> ##4 (done_q && branchTaken_q && pc_q == $past(relTarget, 4)))
        else $error("overflow branch not taken to target");

    AST_POS_TAKEN: assert property (@(posedge mclk) disable iff (!rst_n)
        accept && opcode == fbsc_pkg::OP_POS_REL
        |-> ##4 (done_q && branchTaken_q == !$past(signFlag, 4)))
        else $error("non-negative branch decision wrong");

    AST_FETCH_LEN: assert property (@(posedge mclk) disable iff (!rst_n)
        accept |=> (fetchLen_q == ($past(isAbs) ? 2'h3 : ($past(opcode) == fbsc_pkg::OP_STONE
                    ? 2'h3 : 2'h2))))
        else $error("fetch length wrong");

    AST_ABS_CYCLES: assert property (@(posedge mclk) disable iff (!rst_n)
        accept && isAbs |=> (!done_q)[*4] ##1 done_q)
        else $error("absolute branch cycle count wrong");

    AST_ABS_TARGET: assert property (@(posedge mclk) disable iff (!rst_n)
        accept && opcode == fbsc_pkg::OP_POS_ABS && !signFlag
        |-> ##5 (done_q && pc_q == $past(absAddr, 5)))
        else $error("absolute target wrong");

    AST_STONE_TIME: assert property (@(posedge mclk) disable iff (!rst_n)
        accept && opcode == fbsc_pkg::OP_STONE |-> ##186 (done_q && xLoad_q))
        else $error("stone conversion not done in 185 cycles");

    AST_STONE_FIELDS: assert property (@(posedge mclk) disable iff (!rst_n)
        xLoad_q |-> (xOut_q % 1000) < 140)
        else $error("pounds field out of range");

    AST_STONE_ZERO: assert property (@(posedge mclk) disable iff (!rst_n)
        accept && opcode == fbsc_pkg::OP_STONE && xIn == '0 |-> ##186 (xLoad_q && xOut_q == '0))
        else $error("zero weight not converted to zero");

    AST_NOT_TAKEN: assert property (@(posedge mclk) disable iff (!rst_n)
        accept && opcode == fbsc_pkg::OP_OVF_REL && !overflowFlag
        |-> ##4 (done_q && !branchTaken_q && pc_q == $past(pcIn, 4) + PCW'(2)))
        else $error("not taken branch pc wrong");

endmodule // fbsc_unit

// ### fbsc_unit_tb.sv
// Purpose: Self-checking bench for the flag branch and stone conversion unit.
// Assumes: Latencies, lengths and stone format as handed over; one 10 MHz clock.
// Notes:   The driver notes each expected completion; the monitor compares on done_q.
`timescale 1ns/1ps
module fbsc_unit_tb;
    localparam int PCW   = 16;
    localparam int XW    = 24;
    localparam int LIMIT = 20000;

    typedef struct {
        logic [PCW-1:0] pc;
        logic           taken;
        logic [1:0]     len;
        logic           load;
        logic [XW-1:0]  x;
        int             due;
    } fbsc_note_t;

    logic               mclk;
    logic               rst_n;
    logic               start;
    fbsc_pkg::fbsc_op_t opcode;
    logic [PCW-1:0]     pcIn;
    logic [7:0]         relOffset;
    logic [PCW-1:0]     absAddr;
    logic               overflowFlag;
    logic               signFlag;
    logic [XW-1:0]      xIn;
    logic               busy_q;
    logic               done_q;
    logic [1:0]         fetchLen_q;
    logic               branchTaken_q;
    logic [PCW-1:0]     pc_q;
    logic               xLoad_q;
    logic [XW-1:0]      xOut_q;
    fbsc_note_t         notes[$];
    fbsc_note_t         seen;
    logic [XW-1:0]      lastX;
    int                 cyc;
    int                 miscompares;
    int                 compares;

    fbsc_unit #(.PCW(PCW), .XW(XW)) fbsc_unit_inst (
        .mclk(mclk), .rst_n(rst_n), .start(start), .opcode(opcode), .pcIn(pcIn),
        .relOffset(relOffset), .absAddr(absAddr), .overflowFlag(overflowFlag),
        .signFlag(signFlag), .xIn(xIn), .busy_q(busy_q), .done_q(done_q),
        .fetchLen_q(fetchLen_q), .branchTaken_q(branchTaken_q), .pc_q(pc_q),
        .xLoad_q(xLoad_q), .xOut_q(xOut_q)
    );

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic test_done;
        if (miscompares == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Start stays high after acceptance, so the next call chains back to back and
    // the new operands sit on the inputs while busy, where they must be ignored.
    task automatic issue(input logic [2:0] op, input logic ovf, input logic sgn,
                         input logic [XW-1:0] x);
        fbsc_note_t     n;
        logic [PCW-1:0] pc;
        logic [PCW-1:0] ab;
        logic [7:0]     off;
        logic           isAbs;
        longint         tenths;
        int             k;
        pc = PCW'($urandom);
        ab = PCW'($urandom);
        off = 8'($urandom);
        isAbs = (op == 3'h1 || op == 3'h3);
        opcode <= fbsc_pkg::fbsc_op_t'(op);
        pcIn <= pc;
        relOffset <= off;
        absAddr <= ab;
        overflowFlag <= ovf;
        signFlag <= sgn;
        xIn <= x;
        start <= 1'b1;
        n.taken = (op <= 3'h1) ? ovf : ((op <= 3'h3) ? !sgn : 1'b0);
        n.len = (op == 3'h4) ? fbsc_pkg::STONE_BYTES
              : (isAbs ? fbsc_pkg::ABS_BYTES : fbsc_pkg::REL_BYTES);
        n.pc = !n.taken ? pc + PCW'(n.len)
             : (isAbs ? ab : pc + PCW'(2) + {{(PCW-8){off[7]}}, off});
        n.load = (op == 3'h4);
        tenths = longint'(x) * 10000 / 4535924;
        if (n.load) lastX = XW'((tenths / 140) * 1000 + tenths % 140);
        n.x = lastX;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (busy_q !== 1'b0 && k < 400);
        if (busy_q !== 1'b0) miscompares++;
        n.due = cyc + 1 + int'(n.load ? fbsc_pkg::STONE_CYCLES
                              : (isAbs ? fbsc_pkg::ABS_CYCLES : fbsc_pkg::REL_CYCLES));
        notes.push_back(n);
    endtask

    task automatic idle;
        int k;
        start <= 1'b0;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (notes.size() != 0 && k < 400);
        // Completions still owed when the wait runs out mean a hung unit.
        if (notes.size() != 0) miscompares++;
    endtask

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (rst_n === 1'b1 && done_q === 1'b1) begin
            if (notes.size() == 0) chk(64'h1, 64'h0);
            else begin
                seen = notes.pop_front();
                chk(pc_q, seen.pc);
                chk(branchTaken_q, seen.taken);
                chk(fetchLen_q, seen.len);
                chk(cyc, seen.due);
                chk(xLoad_q, seen.load);
                chk(xOut_q, seen.x);
                chk(busy_q, 64'h0);
            end
        end else if (xLoad_q === 1'b1) chk(64'h1, 64'h0);
    end

    always @(posedge mclk) begin
        if (cyc == LIMIT) begin
            miscompares++;
            test_done();
        end
    end

    initial begin
        rst_n = 1'b0;
        start = 1'b0;
        opcode = fbsc_pkg::OP_OVF_REL;
        pcIn = '0;
        relOffset = 8'h00;
        absAddr = '0;
        overflowFlag = 1'b0;
        signFlag = 1'b0;
        xIn = '0;
        lastX = '0;
        cyc = 0;
        miscompares = 0;
        compares = 0;
        void'($urandom(14));
        repeat (2) @(posedge mclk);
        chk({busy_q, done_q, fetchLen_q, branchTaken_q, pc_q, xLoad_q, xOut_q}, 64'h0);
        rst_n <= 1'b1;
        // Flags walk all four combinations first, then go random; opcodes 5..7 too.
        for (int r = 0; r < 6; r++) begin
            for (int op = 0; op < 8; op++) begin
                issue(3'(op), (r < 4) ? r[0] : 1'($urandom), (r < 4) ? r[1] : 1'($urandom),
                      XW'($urandom));
            end
        end
        issue(3'h4, 1'b0, 1'b0, 24'h000000);
        issue(3'h4, 1'b1, 1'b1, 24'h00f80e);
        issue(3'h4, 1'b0, 1'b1, 24'h00f80f);
        issue(3'h4, 1'b1, 1'b0, 24'hffffff);
        idle();
        // A reset in mid-conversion must abandon it and clear every output.
        issue(3'h4, 1'b0, 1'b0, 24'h123456);
        repeat (20) @(posedge mclk);
        rst_n <= 1'b0;
        start <= 1'b0;
        notes.delete();
        lastX = '0;
        repeat (2) @(posedge mclk);
        chk({busy_q, done_q, fetchLen_q, branchTaken_q, pc_q, xLoad_q, xOut_q}, 64'h0);
        rst_n <= 1'b1;
        issue(3'h1, 1'b1, 1'b0, 24'h000000);
        issue(3'h2, 1'b0, 1'b1, 24'h000000);
        idle();
        test_done();
    end
endmodule // fbsc_unit_tb
